// file: pbs_main.v
`include "pbs_regs.vh"
`default_nettype none

module pbs_main (
   input wire i_ref_clk,
   input wire i_reset,
   input wire [`PBS_SLOT_W-1:0] i_mode_slot,
   input wire [`PBS_PIX_W-1:0] i_black_level,
   input wire [34:0] i_stored_map,
   input wire [6:0] i_stored_valid,
   input wire i_map_we,
   input wire [`PBS_SLOT_W-1:0] i_map_slot,
   input wire [`PBS_IDX_W-1:0] i_map_index,
   output reg o_map_reject,
   output wire o_loading,
   input wire i_pix_valid,
   output wire o_pix_ready,
   input wire [`PBS_PIX_W-1:0] i_pix_data,
   input wire i_pix_sol,
   input wire i_pix_sof,
   output wire o_out_valid,
   input wire i_out_ready,
   output wire [`PBS_PIX_W-1:0] o_out_data,
   output wire o_out_sol,
   output wire o_out_sof,
   output reg [1:0] o_sensor_vbin_log2,
   output reg [`PBS_IDX_W-1:0] o_active_index
);

   // ----------------------------------------
   // Reduction list decode
   // ----------------------------------------
   function [`PBS_MODE_W-1:0] pbs_decode;
      input [`PBS_IDX_W-1:0] idx;
      begin
         case (idx)
            `PBS_IDX_HBIN2: pbs_decode = {`PBS_KIND_BIN, 2'h1, 2'h0, 3'h0};
            `PBS_IDX_HBIN4: pbs_decode = {`PBS_KIND_BIN, 2'h2, 2'h0, 3'h0};
            `PBS_IDX_HBIN8: pbs_decode = {`PBS_KIND_BIN, 2'h3, 2'h0, 3'h0};
            `PBS_IDX_VBIN2: pbs_decode = {`PBS_KIND_BIN, 2'h0, 2'h1, 3'h0};
            `PBS_IDX_VBIN4: pbs_decode = {`PBS_KIND_BIN, 2'h0, 2'h2, 3'h0};
            `PBS_IDX_VBIN8: pbs_decode = {`PBS_KIND_BIN, 2'h0, 2'h3, 3'h0};
            `PBS_IDX_FBIN2: pbs_decode = {`PBS_KIND_BIN, 2'h1, 2'h1, 3'h0};
            `PBS_IDX_FBIN4: pbs_decode = {`PBS_KIND_BIN, 2'h2, 2'h2, 3'h0};
            `PBS_IDX_FBIN8: pbs_decode = {`PBS_KIND_BIN, 2'h3, 2'h3, 3'h0};
            `PBS_IDX_HSUB4: pbs_decode = {`PBS_KIND_SUB, 4'h0, 3'h4};
            `PBS_IDX_HSUB8: pbs_decode = {`PBS_KIND_SUB, 4'h0, 3'h5};
            `PBS_IDX_VSUB4: pbs_decode = {`PBS_KIND_SUB, 4'h0, 3'h2};
            `PBS_IDX_VSUB8: pbs_decode = {`PBS_KIND_SUB, 4'h0, 3'h3};
            `PBS_IDX_FSUB4: pbs_decode = {`PBS_KIND_SUB, 4'h0, 3'h6};
            `PBS_IDX_FSUB8: pbs_decode = {`PBS_KIND_SUB, 4'h0, 3'h7};
            default: pbs_decode = {`PBS_KIND_NONE, 7'h00};
         endcase
      end
   endfunction

   // Keep test for sub-sampling: positions 0 and 1 of every 4 or 8 survive
   function pbs_keep;
      input [`PBS_CNT_W-1:0] pos;
      input p8;
      begin
         if (p8) begin
            pbs_keep = (pos[2:1] == 2'h0);
         end else begin
            pbs_keep = ~pos[1];
         end
      end
   endfunction

   // Factory default per slot
   function [`PBS_IDX_W-1:0] pbs_factory;
      input integer slot;
      begin
         case (slot)
            1: pbs_factory = `PBS_DEF_SLOT1;
            2: pbs_factory = `PBS_DEF_SLOT2;
            3: pbs_factory = `PBS_DEF_SLOT3;
            4: pbs_factory = `PBS_DEF_SLOT4;
            5: pbs_factory = `PBS_DEF_SLOT5;
            6: pbs_factory = `PBS_DEF_SLOT6;
            default: pbs_factory = `PBS_DEF_SLOT7;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Reload after reset
   // ----------------------------------------
   localparam ST_LOAD = 1'b0;
   localparam ST_RUN = 1'b1;

   reg state_ff;
   reg nxt_state;
   reg [`PBS_SLOT_W-1:0] load_slot_ff;
   reg [`PBS_SLOT_W-1:0] nxt_load_slot;

   always @* begin
      nxt_state = state_ff;
      nxt_load_slot = load_slot_ff;
      case (state_ff)
         ST_LOAD: begin
            nxt_load_slot = load_slot_ff + 3'h1;
            if (load_slot_ff == `PBS_SLOTS - 1) begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            nxt_load_slot = 3'h1;
         end
         default: begin
            nxt_state = ST_LOAD;
            nxt_load_slot = 3'h1;
         end
      endcase
   end

   always @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         state_ff <= ST_LOAD;
         load_slot_ff <= 3'h1;
      end else begin
         state_ff <= nxt_state;
         load_slot_ff <= nxt_load_slot;
      end
   end

   assign o_loading = (state_ff == ST_LOAD);

   // ----------------------------------------
   // Active slot table
   // ----------------------------------------
   wire map_ok;
   wire [`PBS_IDX_W*`PBS_SLOTS-1:0] tbl_flat;

   // Slot 0 is hard-wired; index range check is separate from slot number
   assign map_ok = (i_map_slot != 3'h0) && (i_map_index <= `PBS_IDX_LAST);
   assign tbl_flat[`PBS_IDX_W-1:0] = `PBS_IDX_NONE;

   genvar g;
   generate
      for (g = 1; g < `PBS_SLOTS; g = g + 1) begin : gen_slot
         reg [`PBS_IDX_W-1:0] idx_ff;
         always @(posedge i_ref_clk or posedge i_reset) begin
            if (i_reset) begin
               idx_ff <= pbs_factory(g);
            end else if (o_loading && load_slot_ff == g) begin
               if (i_stored_valid[g-1]) begin
                  idx_ff <= i_stored_map[(g-1)*`PBS_IDX_W +: `PBS_IDX_W];
               end
            end else if (!o_loading && i_map_we && map_ok && i_map_slot == g) begin
               idx_ff <= i_map_index;
            end
         end
         assign tbl_flat[g*`PBS_IDX_W +: `PBS_IDX_W] = idx_ff;
      end
   endgenerate

   always @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_map_reject <= 1'b0;
      end else begin
         o_map_reject <= i_map_we & (o_loading | ~map_ok);
      end
   end

   // ----------------------------------------
   // Mode selection at frame start
   // ----------------------------------------
   reg [`PBS_MODE_W-1:0] mode_ff;
   wire [`PBS_IDX_W-1:0] sel_index;
   wire [`PBS_MODE_W-1:0] mode_cur;
   wire buf_in_ready;
   wire accept;

   assign o_pix_ready = buf_in_ready & ~o_loading;
   assign accept = i_pix_valid & o_pix_ready;
   assign sel_index = tbl_flat[i_mode_slot*`PBS_IDX_W +: `PBS_IDX_W];
   assign mode_cur = i_pix_sof ? pbs_decode(sel_index) : mode_ff;

   always @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         mode_ff <= {`PBS_MODE_W{1'b0}};
         o_active_index <= `PBS_IDX_NONE;
      end else if (accept && i_pix_sof) begin
         mode_ff <= pbs_decode(sel_index);
         o_active_index <= sel_index;
      end
   end

   // ----------------------------------------
   // Vertical factor to the sensor
   // ----------------------------------------
   wire [`PBS_MODE_W-1:0] slot_mode;
   wire [1:0] slot_vlog;

   // Sensor sums rows itself, so stream data arrive already vertically binned
   assign slot_mode = pbs_decode(sel_index);
   assign slot_vlog = slot_mode[`PBS_F_VLOG];

   // Held steady in the frame start cycle and during reload; in every other cycle it follows the selected slot
   always @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_sensor_vbin_log2 <= 2'h0;
      end else if (!o_loading && !(accept && i_pix_sof)) begin
         o_sensor_vbin_log2 <= slot_vlog;
      end
   end

   // ----------------------------------------
   // Column and line position
   // ----------------------------------------
   reg [`PBS_CNT_W-1:0] col_ff;
   reg [`PBS_CNT_W-1:0] line_ff;
   wire [`PBS_CNT_W-1:0] pos;
   wire [`PBS_CNT_W-1:0] cur_line;

   assign pos = i_pix_sol ? {`PBS_CNT_W{1'b0}} : col_ff;
   assign cur_line = i_pix_sof ? {`PBS_CNT_W{1'b0}} :
      (i_pix_sol ? line_ff + 16'h0001 : line_ff);

   always @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         col_ff <= {`PBS_CNT_W{1'b0}};
         line_ff <= {`PBS_CNT_W{1'b0}};
      end else if (accept) begin
         col_ff <= pos + 16'h0001;
         line_ff <= cur_line;
      end
   end

   // ----------------------------------------
   // Horizontal binning and sub-sampling
   // ----------------------------------------
   reg [`PBS_SUM_W-1:0] acc_ff;
   reg pend_sol_ff;
   reg pend_sof_ff;
   reg [`PBS_PIX_W-1:0] out_value;
   wire [1:0] hlog;
   wire [2:0] grp_mask;
   wire [2:0] grp_pos;
   wire grp_first;
   wire grp_last;
   wire [`PBS_SUM_W-1:0] sum_now;
   wire [`PBS_SUM_W-1:0] off_sum;
   wire [`PBS_SUM_W:0] diff;
   wire keep;
   wire push;
   wire sol_tag;
   wire sof_tag;

   assign hlog = mode_cur[`PBS_F_HLOG];
   assign grp_mask = (3'h1 << hlog) - 3'h1;
   assign grp_pos = pos[2:0] & grp_mask;
   assign grp_first = (grp_pos == 3'h0);
   assign grp_last = (grp_pos == grp_mask);
   // Sums the group; after vertical binning in the sensor this is the full square
   assign sum_now = (grp_first ? {`PBS_SUM_W{1'b0}} : acc_ff) +
      {3'h0, i_pix_data};
   // Removes the extra black offsets so only one remains
   assign off_sum = ({3'h0, i_black_level} << hlog) - {3'h0, i_black_level};
   assign diff = {1'b0, sum_now} - {1'b0, off_sum};

   always @* begin
      if (diff[`PBS_SUM_W]) begin
         out_value = {`PBS_PIX_W{1'b0}};
      end else if (diff[`PBS_SUM_W-1:0] > {3'h0, `PBS_PIX_MAX}) begin
         out_value = `PBS_PIX_MAX;
      end else begin
         out_value = diff[`PBS_PIX_W-1:0];
      end
   end

   // Sub-sampling drops pixels and lines, never sums them
   assign keep = (!mode_cur[`PBS_F_HSUB] || pbs_keep(pos, mode_cur[`PBS_F_P8])) &&
      (!mode_cur[`PBS_F_VSUB] || pbs_keep(cur_line, mode_cur[`PBS_F_P8]));
   assign push = accept & keep & grp_last;
   assign sol_tag = pend_sol_ff | i_pix_sol;
   assign sof_tag = pend_sof_ff | i_pix_sof;

   always @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         acc_ff <= {`PBS_SUM_W{1'b0}};
         pend_sol_ff <= 1'b0;
         pend_sof_ff <= 1'b0;
      end else if (accept) begin
         acc_ff <= sum_now;
         pend_sol_ff <= sol_tag & ~push;
         pend_sof_ff <= sof_tag & ~push;
      end
   end

   // ----------------------------------------
   // Output buffer
   // ----------------------------------------
   wire [`PBS_BUF_W-1:0] buf_out;

   pbs_buf2 #(
      .W(`PBS_BUF_W)
   ) u_buf (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_in_valid(push),
      .o_in_ready(buf_in_ready),
      .i_in_data({sof_tag, sol_tag, out_value}),
      .o_out_valid(o_out_valid),
      .i_out_ready(i_out_ready),
      .o_out_data(buf_out)
   );

   assign o_out_data = buf_out[`PBS_PIX_W-1:0];
   assign o_out_sol = buf_out[`PBS_PIX_W];
   assign o_out_sof = buf_out[`PBS_PIX_W+1];

endmodule

`default_nettype wire

// file: pbs_regs.vh
`ifndef PBS_REGS_VH
`define PBS_REGS_VH

// ----------------------------------------
// Stream widths
// ----------------------------------------
`define PBS_PIX_W 12
`define PBS_PIX_MAX 12'hFFF
`define PBS_SUM_W 15
`define PBS_BUF_W 14
`define PBS_CNT_W 16

// ----------------------------------------
// Mode slots and reduction list indices
// ----------------------------------------
`define PBS_SLOT_W 3
`define PBS_SLOTS 8
`define PBS_IDX_W 5
`define PBS_IDX_LAST 5'h1B
`define PBS_IDX_NONE 5'h00
`define PBS_IDX_HBIN2 5'h01
`define PBS_IDX_HBIN4 5'h02
`define PBS_IDX_HBIN8 5'h03
`define PBS_IDX_VBIN2 5'h04
`define PBS_IDX_VBIN4 5'h05
`define PBS_IDX_VBIN8 5'h06
`define PBS_IDX_FBIN2 5'h07
`define PBS_IDX_FBIN4 5'h08
`define PBS_IDX_FBIN8 5'h09
`define PBS_IDX_HSUB4 5'h0A
`define PBS_IDX_HSUB8 5'h0B
`define PBS_IDX_VSUB4 5'h0C
`define PBS_IDX_VSUB8 5'h0D
`define PBS_IDX_FSUB4 5'h0E
`define PBS_IDX_FSUB8 5'h0F

// ----------------------------------------
// Factory slot defaults
// ----------------------------------------
`define PBS_DEF_SLOT1 `PBS_IDX_HBIN2
`define PBS_DEF_SLOT2 `PBS_IDX_VBIN2
`define PBS_DEF_SLOT3 `PBS_IDX_FBIN2
`define PBS_DEF_SLOT4 `PBS_IDX_HSUB4
`define PBS_DEF_SLOT5 `PBS_IDX_VSUB4
`define PBS_DEF_SLOT6 `PBS_IDX_FSUB4
`define PBS_DEF_SLOT7 `PBS_IDX_NONE

// ----------------------------------------
// Decoded mode word {kind, hlog, vlog, hsub, vsub, p8}
// ----------------------------------------
`define PBS_MODE_W 9
`define PBS_KIND_NONE 2'h0
`define PBS_KIND_BIN 2'h1
`define PBS_KIND_SUB 2'h2
`define PBS_F_KIND 8:7
`define PBS_F_HLOG 6:5
`define PBS_F_VLOG 4:3
`define PBS_F_HSUB 2
`define PBS_F_VSUB 1
`define PBS_F_P8 0

`endif

// file: pbs_buf2.v
`include "pbs_regs.vh"
`default_nettype none

// Two-entry buffer: output register plus one skid register
module pbs_buf2 #(
   parameter W = `PBS_BUF_W
) (
   input wire i_ref_clk,
   input wire i_reset,
   input wire i_in_valid,
   output wire o_in_ready,
   input wire [W-1:0] i_in_data,
   output wire o_out_valid,
   input wire i_out_ready,
   output wire [W-1:0] o_out_data
);

   reg [W-1:0] out_data_ff;
   reg out_valid_ff;
   reg [W-1:0] skid_data_ff;
   reg skid_valid_ff;
   wire take_in;
   wire move_out;

   assign o_in_ready = ~skid_valid_ff;
   assign take_in = i_in_valid & ~skid_valid_ff;
   assign move_out = ~out_valid_ff | i_out_ready;
   assign o_out_valid = out_valid_ff;
   assign o_out_data = out_data_ff;

   always @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         out_data_ff <= {W{1'b0}};
         out_valid_ff <= 1'b0;
         skid_data_ff <= {W{1'b0}};
         skid_valid_ff <= 1'b0;
      end else if (move_out) begin
         if (skid_valid_ff) begin
            out_data_ff <= skid_data_ff;
            out_valid_ff <= 1'b1;
            skid_valid_ff <= 1'b0;
         end else begin
            out_data_ff <= i_in_data;
            out_valid_ff <= take_in;
         end
      end else if (take_in) begin
         skid_data_ff <= i_in_data;
         skid_valid_ff <= 1'b1;
      end
   end

endmodule

`default_nettype wire

// file: pbs_sink.sv
`default_nettype none
module pbs_sink (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_slow,
   input wire logic i_valid,
   output logic o_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ready_ff;

   assign o_ready = ready_ff;

   // ----------------------------------------
   // Output pipeline: slow mode refuses every other offered word
   // ----------------------------------------
   always @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset)
         ready_ff <= 1'b0;
      else if (!i_slow)
         ready_ff <= 1'b1;
      else if (i_valid)
         ready_ff <= ~ready_ff;
   end
endmodule
`default_nettype wire

// file: pbs_main_sva.sv
`include "pbs_regs.vh"
`default_nettype none
module pbs_main_sva (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic [2:0] i_mode_slot,
   input wire logic i_map_we,
   input wire logic [2:0] i_map_slot,
   input wire logic [4:0] i_map_index,
   input wire logic o_map_reject,
   input wire logic o_loading,
   input wire logic i_pix_valid,
   input wire logic o_pix_ready,
   input wire logic i_pix_sof,
   input wire logic o_out_valid,
   input wire logic i_out_ready,
   input wire logic [11:0] o_out_data,
   input wire logic o_out_sol,
   input wire logic o_out_sof,
   input wire logic [4:0] o_active_index
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);

   // ----------------------------------------
   // Steps
   // ----------------------------------------
   sequence map_try;
      i_map_we && !o_loading;
   endsequence
   sequence sof_take;
      i_pix_valid && o_pix_ready && i_pix_sof;
   endsequence

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   reject_slot0_a: assert property (map_try ##0 i_map_slot == 3'h0 |=> o_map_reject)
      else $error("slot 0 remap not refused");
   reject_range_a: assert property (map_try ##0 i_map_index > 5'h1B |=> o_map_reject)
      else $error("index above list not refused");
   map_accept_a: assert property (map_try ##0 (i_map_slot != 3'h0 && i_map_index <= 5'h1B)
      |=> !o_map_reject)
      else $error("legal remap refused");
   reload_bound_a: assert property (o_loading |-> ##[0:7] !o_loading)
      else $error("reload longer than seven cycles");
   ready_gate_a: assert property (o_loading |-> !o_pix_ready)
      else $error("pixel taken during reload");
   out_hold_a: assert property (o_out_valid && !i_out_ready
      |=> o_out_valid && $stable(o_out_data) && $stable(o_out_sof))
      else $error("stalled word changed");
   sof_sol_a: assert property (o_out_valid && o_out_sof |-> o_out_sol)
      else $error("frame start without line start");
   slot0_full_a: assert property (sof_take ##0 i_mode_slot == 3'h0
      |=> o_active_index == `PBS_IDX_NONE)
      else $error("slot 0 not full resolution");
endmodule

bind pbs_main pbs_main_sva i_chk (.i_ref_clk, .i_reset, .i_mode_slot, .i_map_we, .i_map_slot,
   .i_map_index, .o_map_reject, .o_loading, .i_pix_valid, .o_pix_ready, .i_pix_sof,
   .o_out_valid, .i_out_ready, .o_out_data, .o_out_sol, .o_out_sof, .o_active_index);
`default_nettype wire

// file: testbench.sv
`include "pbs_regs.vh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] BLK = 12'h040;
   logic i_ref_clk, i_reset, i_map_we, i_pix_valid, i_pix_sol, i_pix_sof, slow;
   logic [2:0] i_mode_slot, i_map_slot;
   logic [11:0] i_pix_data, out_data;
   logic [34:0] i_stored_map;
   logic [6:0] i_stored_valid;
   logic [4:0] i_map_index, act_idx;
   logic map_reject, loading, pix_ready, out_valid, out_ready, out_sol, out_sof;
   logic [1:0] vbin;
   logic [13:0] outq[$];
   int n_fail, n_compared;

   pbs_main i_dut (.i_ref_clk, .i_reset, .i_mode_slot, .i_black_level(BLK), .i_stored_map,
      .i_stored_valid, .i_map_we, .i_map_slot, .i_map_index, .o_map_reject(map_reject),
      .o_loading(loading), .i_pix_valid, .o_pix_ready(pix_ready), .i_pix_data, .i_pix_sol,
      .i_pix_sof, .o_out_valid(out_valid), .i_out_ready(out_ready), .o_out_data(out_data),
      .o_out_sol(out_sol), .o_out_sof(out_sof), .o_sensor_vbin_log2(vbin),
      .o_active_index(act_idx));
   pbs_sink i_sink (.i_ref_clk, .i_reset, .i_slow(slow), .i_valid(out_valid),
      .o_ready(out_ready));

   initial begin
      i_ref_clk = 1'b0;
      forever #12.5 i_ref_clk = ~i_ref_clk;
   end

   always @(posedge i_ref_clk) begin
      if (out_valid && out_ready)
         outq.push_back({out_sol, out_sof, out_data});
   end

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic end_of_test();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic give_up(input string nm);
      chk(nm, 16'h0001, 16'h0000);
      end_of_test();
   endtask

   task automatic do_reset(input logic [6:0] sv);
      int n;
      @(posedge i_ref_clk);
      i_stored_valid <= sv;
      i_reset <= 1'b1;
      repeat (5) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      chk("loading_rst", 16'h1, loading);
      chk("ready_rst", 16'h0, pix_ready);
      @(posedge i_ref_clk);
      i_reset <= 1'b0;
      i_map_we <= 1'b1;
      i_map_slot <= 3'h1;
      i_map_index <= `PBS_IDX_HBIN8;
      for (n = 1; n < 20; n++) begin
         @(posedge i_ref_clk);
         i_map_we <= 1'b0;
         @(negedge i_ref_clk);
         if (n == 1) chk("reject_load", 16'h1, map_reject);
         if (!loading) break;
      end
      chk("reload_edges", 16'd7, 16'(n));
   endtask

   task automatic map_wr(input logic [2:0] s, input logic [4:0] x, input logic e);
      @(posedge i_ref_clk);
      i_map_we <= 1'b1;
      i_map_slot <= s;
      i_map_index <= x;
      @(posedge i_ref_clk);
      i_map_we <= 1'b0;
      @(negedge i_ref_clk);
      chk("map_reject", 16'(e), map_reject);
   endtask

   task automatic run_frame(input logic [2:0] s, input logic [4:0] idx, input int w,
         input int ln, input logic [11:0] base);
      logic [13:0] exp[$];
      logic [11:0] v;
      logic rdy, ln_new;
      int acc, r, t, hn, km, hk, vk;
      logic [1:0] vl;
      hn = 1; km = 1; hk = 0; vk = 0; vl = 2'h0; acc = 0; ln_new = 1'b0;
      if (idx >= 1 && idx <= 3) hn = 1 << idx;
      if (idx >= 7 && idx <= 9) hn = 1 << (idx - 6);
      if (idx >= 4 && idx <= 9) vl = 2'((idx - 1) % 3 + 1);
      if (idx >= 10 && idx <= 15) begin
         km = idx[0] ? 8 : 4;
         hk = (idx != 12 && idx != 13);
         vk = (idx >= 12);
      end
      outq.delete();
      @(posedge i_ref_clk);
      i_mode_slot <= s;
      for (int l = 0; l < ln; l++) begin
         for (int c = 0; c < w; c++) begin
            v = base + 12'(17 * c + 5 * l);
            i_pix_valid <= 1'b1;
            i_pix_data <= v;
            i_pix_sol <= (c == 0);
            i_pix_sof <= (c == 0 && l == 0);
            if (c == 0) ln_new = 1'b1;
            if (hn > 1) begin
               acc += v;
               if (c % hn == hn - 1) begin
                  r = acc - (hn - 1) * BLK;
                  r = (r > 4095) ? 4095 : r;
                  exp.push_back({ln_new, exp.size() == 0, 12'(r)});
                  ln_new = 1'b0;
                  acc = 0;
               end
            end else if ((!hk || c % km < 2) && (!vk || l % km < 2)) begin
               exp.push_back({ln_new, exp.size() == 0, v});
               ln_new = 1'b0;
            end
            t = 0;
            do begin
               @(negedge i_ref_clk);
               rdy = pix_ready;
               @(posedge i_ref_clk);
               t++;
            end while (!rdy && t < 100);
            if (!rdy) give_up("pix_accept");
         end
      end
      i_pix_valid <= 1'b0;
      for (t = 0; t < 400 && outq.size() < exp.size(); t++) @(posedge i_ref_clk);
      if (t == 400) give_up("out_wait");
      repeat (6) @(posedge i_ref_clk);
      chk("word_count", 16'(exp.size()), 16'(outq.size()));
      foreach (exp[i]) if (i < outq.size()) chk("word", exp[i], outq[i]);
      chk("active_index", idx, act_idx);
      chk("sensor_vbin", vl, vbin);
   endtask

   task automatic check_defaults();
      logic [4:0] d_t[7] = '{`PBS_IDX_NONE, `PBS_DEF_SLOT1, `PBS_DEF_SLOT2, `PBS_DEF_SLOT3,
         `PBS_DEF_SLOT4, `PBS_DEF_SLOT5, `PBS_DEF_SLOT6};
      for (int s = 0; s < 7; s++) begin
         slow <= s[0];
         run_frame(3'(s), d_t[s], 8, 4, 12'h100);
      end
   endtask

   task automatic check_remap();
      logic [4:0] r_t[7] = '{`PBS_IDX_HBIN4, `PBS_IDX_HBIN8, `PBS_IDX_HSUB8, `PBS_IDX_VSUB8,
         `PBS_IDX_FSUB8, `PBS_IDX_FBIN8, 5'h1B};
      map_wr(3'h0, `PBS_IDX_HBIN2, 1'b1);
      run_frame(3'h0, `PBS_IDX_NONE, 8, 1, 12'h200);
      map_wr(3'h7, 5'h1C, 1'b1);
      foreach (r_t[i]) begin
         slow <= ~slow;
         map_wr(3'h7, r_t[i], 1'b0);
         run_frame(3'h7, r_t[i], 16, 8, 12'hF00);
      end
   endtask

   task automatic check_stored();
      do_reset(7'h06);
      run_frame(3'h2, `PBS_IDX_HBIN4, 8, 2, 12'h100);
      run_frame(3'h3, `PBS_IDX_HSUB8, 16, 2, 12'h100);
   endtask

   initial begin
      n_fail = 0;
      n_compared = 0;
      i_reset = 1'b1;
      slow = 1'b0;
      i_map_we = 1'b0;
      i_map_slot = 3'h0;
      i_map_index = 5'h00;
      i_mode_slot = 3'h0;
      i_pix_valid = 1'b0;
      i_pix_data = 12'h000;
      i_pix_sol = 1'b0;
      i_pix_sof = 1'b0;
      i_stored_valid = 7'h00;
      i_stored_map = {20'h00000, `PBS_IDX_HSUB8, `PBS_IDX_HBIN4, 5'h00};
      do_reset(7'h00);
      check_defaults();
      check_remap();
      check_stored();
      end_of_test();
   end
endmodule
`default_nettype wire
